/* common/cbf_pkg.sv */
/*
 holds the register map, field positions, reset values and carrier types of
 the comparator blanking filter.
 assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock.
*/
// Summary of operation
// RULE1: the top bit of the mask gating register picks whether low or high comparator states are blanked, and 1 blocks low states.
// RULE2: each true mask input enters the OR gate only while its enable bit (13, 11, 9 for C, B, A) is set.
// RULE3: each inverted mask input enters the OR gate only while its inverted enable bit (12, 10, 8 for C, B, A) is set.
// RULE4: each true mask input enters the AND gate only while its enable bit (5, 3, 1 for C, B, A) is set.
// RULE5: each inverted mask input enters the AND gate only while its inverted enable bit (4, 2, 0 for C, B, A) is set.
// RULE6: the AND result enters the OR gate when bit 6 is set, and its inverse when bit 7 is set.
// RULE7: unused inputs count as one at the AND gate and zero at the OR gate, and the OR output is the blanking signal; code: AND output 0 with no AND input.
// RULE8: the filter enable bit turns the digital filter on, otherwise the comparator output passes unfiltered.
// RULE9: a 3-bit source select picks timer 5 to 2, two PWM sync outputs, the oscillator or the peripheral clock.
// RULE10: a 3-bit divide field scales the chosen filter clock from 1:1 up to 1:128.
// RULE11: each reference control register powers its reference while bit 7 is set.
// RULE12: a 2-bit range select, bits 11 and 5, chooses the reference span and step with the level code.
// RULE13: each mask input is chosen by its own 4-bit selector from sixteen sources.
`default_nettype none
package cbf_pkg;
   localparam logic [7:0] ADDR_MASK_GATE = 8'h00;
   localparam logic [7:0] ADDR_FILTER    = 8'h04;
   localparam logic [7:0] ADDR_REF_ONE   = 8'h08;
   localparam logic [7:0] ADDR_REF_TWO   = 8'h0C;
   localparam logic [7:0] ADDR_MASK_SRC  = 8'h10;
   localparam logic [7:0] ADDR_STATUS    = 8'h14;

   localparam logic [15:0] MASK_GATE_RW = 16'hBFFF;
   localparam logic [15:0] FILTER_RW    = 16'h007F;
   localparam logic [15:0] REF_RW       = 16'h0CFF;
   localparam logic [15:0] MASK_SRC_RW  = 16'h0FFF;
   localparam logic [15:0] REG_RESET    = 16'h0000;

   localparam int BIT_POLARITY   = 15;
   localparam int BIT_OR_C       = 13;
   localparam int BIT_OR_CN      = 12;
   localparam int BIT_OR_B       = 11;
   localparam int BIT_OR_BN      = 10;
   localparam int BIT_OR_A       = 9;
   localparam int BIT_OR_AN      = 8;
   localparam int BIT_AND_INV_OR = 7;
   localparam int BIT_AND_TO_OR  = 6;
   localparam int BIT_AND_C      = 5;
   localparam int BIT_AND_CN     = 4;
   localparam int BIT_AND_B      = 3;
   localparam int BIT_AND_BN     = 2;
   localparam int BIT_AND_A      = 1;
   localparam int BIT_AND_AN     = 0;

   localparam int BIT_FILT_EN    = 3;
   localparam int FILT_SRC_LSB   = 4;
   localparam int FILT_DIV_LSB   = 0;
   localparam int SRC_A_LSB      = 0;
   localparam int SRC_B_LSB      = 4;
   localparam int SRC_C_LSB      = 8;

   localparam int BIT_REF_EN     = 7;
   localparam int BIT_REF_OE     = 6;
   localparam int BIT_RANGE_HI   = 11;
   localparam int BIT_RANGE_LO   = 5;
   localparam int BIT_REF_SS     = 4;
   localparam int BIT_REF_SEL    = 10;
   localparam int LEVEL_LSB      = 0;

   localparam int FILTER_DEPTH   = 3;
   localparam int DIV_WIDTH      = 7;
   localparam int CLOCK_HZ       = 10_000_000;
   localparam int PERIOD_NS      = 1_000_000_000 / CLOCK_HZ;

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef struct packed {
      logic       power_on;
      logic       level_out_en;
      logic [1:0] range_sel;
      logic       source_sel;
      logic       ext_ref_sel;
      logic [3:0] level_code;
   } cbf_ref_type;

   typedef struct packed {
      logic [3:0] timer_clk;
      logic [1:0] pwm_sync;
      logic       osc_clk;
      logic       periph_clk;
   } cbf_clk_type;
endpackage
`default_nettype wire

/* design/cbf_blank_gate.sv */
/*
 combines the three mask inputs through the AND and OR gates into the
 blanking signal.
 assumes mask inputs already synchronous to aclk.
*/
`default_nettype none
module cbf_blank_gate (
   input  wire logic [15:0] gate_cfg,
   input  wire logic [2:0]  mask_in,
   output logic             and_gate_result,
   output logic             blank
);
   // mask_in index: 0 = A, 1 = B, 2 = C
   wire logic a_t = gate_cfg[cbf_pkg::BIT_AND_A] ? mask_in[0] : 1'b1;  // RULE4
   wire logic b_t = gate_cfg[cbf_pkg::BIT_AND_B] ? mask_in[1] : 1'b1;  // RULE4
   wire logic c_t = gate_cfg[cbf_pkg::BIT_AND_C] ? mask_in[2] : 1'b1;  // RULE4
   wire logic a_n = gate_cfg[cbf_pkg::BIT_AND_AN] ? ~mask_in[0] : 1'b1; // RULE5
   wire logic b_n = gate_cfg[cbf_pkg::BIT_AND_BN] ? ~mask_in[1] : 1'b1; // RULE5
   wire logic c_n = gate_cfg[cbf_pkg::BIT_AND_CN] ? ~mask_in[2] : 1'b1; // RULE5
   wire logic any_and = |{gate_cfg[cbf_pkg::BIT_AND_C:cbf_pkg::BIT_AND_AN]};
   // an AND gate with no input connected stays low, so it blanks only through bit 7
   assign and_gate_result = any_and & a_t & b_t & c_t & a_n & b_n & c_n; // RULE7

   wire logic or_a  = gate_cfg[cbf_pkg::BIT_OR_A]  &  mask_in[0]; // RULE2
   wire logic or_b  = gate_cfg[cbf_pkg::BIT_OR_B]  &  mask_in[1]; // RULE2
   wire logic or_c  = gate_cfg[cbf_pkg::BIT_OR_C]  &  mask_in[2]; // RULE2
   wire logic or_an = gate_cfg[cbf_pkg::BIT_OR_AN] & ~mask_in[0]; // RULE3
   wire logic or_bn = gate_cfg[cbf_pkg::BIT_OR_BN] & ~mask_in[1]; // RULE3
   wire logic or_cn = gate_cfg[cbf_pkg::BIT_OR_CN] & ~mask_in[2]; // RULE3
   wire logic or_p  = gate_cfg[cbf_pkg::BIT_AND_TO_OR] & and_gate_result; // RULE6
   wire logic or_n  = gate_cfg[cbf_pkg::BIT_AND_INV_OR]
                      & ~and_gate_result; // RULE6
   assign blank = or_a | or_b | or_c | or_an | or_bn | or_cn
                  | or_p | or_n; // RULE7
endmodule
`default_nettype wire

/* design/cbf_filter.sv */
/*
 digital three-equal-sample filter on the comparator output, sampled on a divided,
 selected clock enable.
 assumes clock sources arrive as levels synchronous to aclk.
*/
`default_nettype none
module cbf_filter #(
   parameter int DEPTH = cbf_pkg::FILTER_DEPTH
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                enable,
   input  wire logic [2:0]          src_sel,
   input  wire logic [2:0]          div_sel,
   input  wire cbf_pkg::cbf_clk_type clk_src,
   input  wire logic                cmp_in,
   output logic                     cmp_out
);
   logic       src_sel_lvl;
   logic       src_prev_reg;
   logic [cbf_pkg::DIV_WIDTH-1:0] div_reg;
   logic [DEPTH-1:0] hist_reg;
   logic       filt_reg;

   // codes 111..100 timers 5..2, 011/010 pwm sync, 001 osc, 000 periph
   always_comb begin // RULE9
      unique case (src_sel)
         3'h7: src_sel_lvl = clk_src.timer_clk[3];
         3'h6: src_sel_lvl = clk_src.timer_clk[2];
         3'h5: src_sel_lvl = clk_src.timer_clk[1];
         3'h4: src_sel_lvl = clk_src.timer_clk[0];
         3'h3: src_sel_lvl = clk_src.pwm_sync[1];
         3'h2: src_sel_lvl = clk_src.pwm_sync[0];
         3'h1: src_sel_lvl = clk_src.osc_clk;
         3'h0: src_sel_lvl = clk_src.periph_clk;
      endcase
   end

   // oscillator and peripheral clock equal aclk here, so they tick each cycle
   wire logic fast_src = (src_sel == 3'h0) || (src_sel == 3'h1);
   wire logic src_tick = fast_src | (src_sel_lvl & ~src_prev_reg);
   wire logic [cbf_pkg::DIV_WIDTH-1:0] div_mask =
      cbf_pkg::DIV_WIDTH'((1 << div_sel) - 1);
   wire logic sample_en = src_tick && ((div_reg & div_mask) == div_mask); // RULE10
   wire logic all_hi = &{hist_reg[DEPTH-2:0], cmp_in};
   wire logic all_lo = ~|{hist_reg[DEPTH-2:0], cmp_in};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev_reg <= 1'b0;
         div_reg      <= '0;
         hist_reg     <= '0;
         filt_reg     <= 1'b0;
      end else begin
         src_prev_reg <= src_sel_lvl;
         if (src_tick)
            div_reg <= div_reg + 1'b1;
         if (sample_en) begin
            hist_reg <= {hist_reg[DEPTH-2:0], cmp_in};
            if (all_hi)
               filt_reg <= 1'b1;
            else if (all_lo)
               filt_reg <= 1'b0;
         end
      end
   end

   assign cmp_out = enable ? filt_reg : cmp_in; // RULE8
endmodule
`default_nettype wire

/* design/cbf_top.sv */
/*
 comparator blanking filter: AXI4-Lite register file, mask source
 selection, blanking gates, output filter and reference ladder controls.
 assumes all inputs synchronous to aclk; reference outputs go to analogue.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module cbf_top (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 cmp_raw,
   input  wire logic [15:0]          mask_sources,
   input  wire cbf_pkg::cbf_clk_type filter_clocks,
   output logic                      cmp_conditioned,
   output logic                      blank_active,
   output cbf_pkg::cbf_ref_type      ref_one,
   output cbf_pkg::cbf_ref_type      ref_two
);
   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [15:0] mask_gate_reg;
   logic [15:0] filter_reg;
   logic [15:0] ref_one_reg;
   logic [15:0] ref_two_reg;
   logic [15:0] mask_src_reg;
   logic [7:0]  awaddr_reg;
   logic        aw_held_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        w_held_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        awready_reg;
   logic        wready_reg;
   logic        arready_reg;
   logic        cmp_out_reg;
   logic        blank_reg;
   cbf_pkg::cbf_ref_type ref_one_reg_o;
   cbf_pkg::cbf_ref_type ref_two_reg_o;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb,
                                           input logic [15:0] rw);
      logic [15:0] v;
      v = old;
      if (strb[0])
         v[7:0] = data[7:0];
      if (strb[1])
         v[15:8] = data[15:8];
      return v & rw;
   endfunction

   function automatic cbf_pkg::cbf_ref_type ref_fields(input logic [15:0] r);
      cbf_pkg::cbf_ref_type f;
      f.power_on     = r[cbf_pkg::BIT_REF_EN];                  // RULE11
      f.level_out_en = r[cbf_pkg::BIT_REF_OE];
      f.range_sel    = {r[cbf_pkg::BIT_RANGE_HI],
                        r[cbf_pkg::BIT_RANGE_LO]};              // RULE12
      f.source_sel   = r[cbf_pkg::BIT_REF_SS];
      f.ext_ref_sel  = r[cbf_pkg::BIT_REF_SEL];
      f.level_code   = r[cbf_pkg::LEVEL_LSB +: 4];               // RULE12
      return f;
   endfunction

   function automatic logic addr_known(input logic [7:0] a);
      return (a == cbf_pkg::ADDR_MASK_GATE) || (a == cbf_pkg::ADDR_FILTER)
          || (a == cbf_pkg::ADDR_REF_ONE)   || (a == cbf_pkg::ADDR_REF_TWO)
          || (a == cbf_pkg::ADDR_MASK_SRC)  || (a == cbf_pkg::ADDR_STATUS);
   endfunction

   // -----------------------------------------------------------------
   // write channel: address and data taken in either order
   // -----------------------------------------------------------------
   wire logic        aw_take = s_axi_awvalid && awready_reg;
   wire logic        w_take  = s_axi_wvalid && wready_reg;
   wire logic        aw_have = aw_held_reg || aw_take;
   wire logic        w_have  = w_held_reg || w_take;
   wire logic        wr_go   = aw_have && w_have && !bvalid_reg;
   wire logic [7:0]  wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   wire logic [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
   wire logic [3:0]  wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
   wire logic        bv_next = wr_go || (bvalid_reg && !s_axi_bready);
   wire logic        wr_ok   = addr_known(wr_addr)
                               && (wr_addr != cbf_pkg::ADDR_STATUS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= cbf_pkg::AXI_OKAY;
      end else begin
         if (aw_take) begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         aw_held_reg <= aw_have && !wr_go;
         w_held_reg  <= w_have && !wr_go;
         // ready mirrors "nothing held, no response due" from a flop
         awready_reg <= !(aw_have && !wr_go) && !bv_next;
         wready_reg  <= !(w_have && !wr_go) && !bv_next;
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? cbf_pkg::AXI_OKAY : cbf_pkg::AXI_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   wire logic wr_gate = wr_go && (wr_addr == cbf_pkg::ADDR_MASK_GATE);
   wire logic wr_filt = wr_go && (wr_addr == cbf_pkg::ADDR_FILTER);
   wire logic wr_ref1 = wr_go && (wr_addr == cbf_pkg::ADDR_REF_ONE);
   wire logic wr_ref2 = wr_go && (wr_addr == cbf_pkg::ADDR_REF_TWO);
   wire logic wr_msrc = wr_go && (wr_addr == cbf_pkg::ADDR_MASK_SRC);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_gate_reg <= cbf_pkg::REG_RESET;
         filter_reg    <= cbf_pkg::REG_RESET;
         ref_one_reg   <= cbf_pkg::REG_RESET;
         ref_two_reg   <= cbf_pkg::REG_RESET;
         mask_src_reg  <= cbf_pkg::REG_RESET;
      end else begin
         if (wr_gate)
            mask_gate_reg <= merge16(mask_gate_reg, wr_data, wr_strb,
                                     cbf_pkg::MASK_GATE_RW);
         if (wr_filt)
            filter_reg <= merge16(filter_reg, wr_data, wr_strb,
                                  cbf_pkg::FILTER_RW);
         if (wr_ref1)
            ref_one_reg <= merge16(ref_one_reg, wr_data, wr_strb,
                                   cbf_pkg::REF_RW);
         if (wr_ref2)
            ref_two_reg <= merge16(ref_two_reg, wr_data, wr_strb,
                                   cbf_pkg::REF_RW);
         if (wr_msrc)
            mask_src_reg <= merge16(mask_src_reg, wr_data, wr_strb,
                                    cbf_pkg::MASK_SRC_RW);
      end
   end

   // -----------------------------------------------------------------
   // read channel: one cycle after the address is taken
   // -----------------------------------------------------------------
   wire logic ar_take = s_axi_arvalid && arready_reg;
   wire logic [15:0] status_word = {13'h0000, blank_reg, cmp_raw,
                                    cmp_out_reg};
   logic [15:0] rd_word;
   always_comb begin
      unique case (s_axi_araddr)
         cbf_pkg::ADDR_MASK_GATE: rd_word = mask_gate_reg;
         cbf_pkg::ADDR_FILTER:    rd_word = filter_reg;
         cbf_pkg::ADDR_REF_ONE:   rd_word = ref_one_reg;
         cbf_pkg::ADDR_REF_TWO:   rd_word = ref_two_reg;
         cbf_pkg::ADDR_MASK_SRC:  rd_word = mask_src_reg;
         cbf_pkg::ADDR_STATUS:    rd_word = status_word;
         default:                 rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= cbf_pkg::AXI_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= {16'h0000, rd_word};
         rresp_reg  <= addr_known(s_axi_araddr) ? cbf_pkg::AXI_OKAY
                                                : cbf_pkg::AXI_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         arready_reg <= 1'b1;
      else
         arready_reg <= !ar_take && !(rvalid_reg && !s_axi_rready);
   end

   // -----------------------------------------------------------------
   // mask selection, blanking and filter
   // -----------------------------------------------------------------
   wire logic [3:0] sel_a = mask_src_reg[cbf_pkg::SRC_A_LSB +: 4];
   wire logic [3:0] sel_b = mask_src_reg[cbf_pkg::SRC_B_LSB +: 4];
   wire logic [3:0] sel_c = mask_src_reg[cbf_pkg::SRC_C_LSB +: 4];
   wire logic [2:0] mask_in = {mask_sources[sel_c], mask_sources[sel_b],
                               mask_sources[sel_a]}; // RULE13
   logic and_unused;
   logic blank_now;
   logic cmp_filtered;

   cbf_blank_gate u_gate (
      .gate_cfg        (mask_gate_reg),
      .mask_in         (mask_in),
      .and_gate_result (and_unused),
      .blank           (blank_now)
   );

   cbf_filter u_filter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (filter_reg[cbf_pkg::BIT_FILT_EN]),
      .src_sel (filter_reg[cbf_pkg::FILT_SRC_LSB +: 3]),
      .div_sel (filter_reg[cbf_pkg::FILT_DIV_LSB +: 3]),
      .clk_src (filter_clocks),
      .cmp_in  (cmp_raw),
      .cmp_out (cmp_filtered)
   );

   // blanking forces the opposite of the suppressed level; holding the
   // last passed value could leave a suppressed level standing
   wire logic cmp_block = mask_gate_reg[cbf_pkg::BIT_POLARITY]; // RULE1

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_out_reg   <= 1'b0;
         blank_reg     <= 1'b0;
         ref_one_reg_o <= '0;
         ref_two_reg_o <= '0;
      end else begin
         cmp_out_reg   <= blank_now ? cmp_block : cmp_filtered; // RULE1
         blank_reg     <= blank_now;                            // RULE7
         ref_one_reg_o <= ref_fields(ref_one_reg);              // RULE11
         ref_two_reg_o <= ref_fields(ref_two_reg);              // RULE11
      end
   end

   assign s_axi_awready   = awready_reg;
   assign s_axi_wready    = wready_reg;
   assign s_axi_bvalid    = bvalid_reg;
   assign s_axi_bresp     = bresp_reg;
   assign s_axi_arready   = arready_reg;
   assign s_axi_rvalid    = rvalid_reg;
   assign s_axi_rdata     = rdata_reg;
   assign s_axi_rresp     = rresp_reg;
   assign cmp_conditioned = cmp_out_reg;
   assign blank_active    = blank_reg;
   assign ref_one         = ref_one_reg_o;
   assign ref_two         = ref_two_reg_o;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   blank_high_mode_a: assert property (blank_now
      && mask_gate_reg[cbf_pkg::BIT_POLARITY] && $stable(mask_gate_reg)
      |=> cmp_conditioned) // RULE1
      else $error("low state passed while blanked");
   blank_low_mode_a: assert property (blank_now
      && !mask_gate_reg[cbf_pkg::BIT_POLARITY] |=> !cmp_conditioned) // RULE1
      else $error("high state passed while blanked");
   or_true_c_a: assert property (mask_gate_reg[cbf_pkg::BIT_OR_C]
      && mask_in[2] |=> blank_active) // RULE2
      else $error("mask c did not blank");
   or_inv_a_a: assert property (mask_gate_reg[cbf_pkg::BIT_OR_AN]
      && !mask_in[0] |=> blank_active) // RULE3
      else $error("inverted mask a did not blank");
   or_none_a: assert property ((mask_gate_reg[13:6] == 8'h00)
      |=> !blank_active) // RULE7
      else $error("blank without any or input");
   and_path_a: assert property (mask_gate_reg[cbf_pkg::BIT_AND_TO_OR]
      && mask_gate_reg[cbf_pkg::BIT_AND_B] && mask_in[1]
      && (mask_gate_reg[5:0] == 6'h08) |=> blank_active) // RULE4
      else $error("and gate path did not blank");
   and_inv_a: assert property (mask_gate_reg[cbf_pkg::BIT_AND_TO_OR]
      && (mask_gate_reg[5:0] == 6'h04) && mask_in[1]
      && (mask_gate_reg[13:8] == 6'h00) && !mask_gate_reg[7]
      |=> !blank_active) // RULE5
      else $error("inverted and input ignored");
   and_inv_out_a: assert property (mask_gate_reg[cbf_pkg::BIT_AND_INV_OR]
      && !and_unused |=> blank_active) // RULE6
      else $error("inverted and result ignored");
   bypass_path_a: assert property (!blank_now
      && !filter_reg[cbf_pkg::BIT_FILT_EN] |=> cmp_conditioned
      == $past(cmp_raw)) // RULE8
      else $error("bypass did not pass comparator");
   ref_power_a: assert property (##1 ref_one.power_on
      == $past(ref_one_reg[cbf_pkg::BIT_REF_EN])) // RULE11
      else $error("reference power not following");
   ref_range_a: assert property (##1 ref_two.range_sel
      == $past({ref_two_reg[cbf_pkg::BIT_RANGE_HI],
                ref_two_reg[cbf_pkg::BIT_RANGE_LO]})) // RULE12
      else $error("range select mismatch");

   blank_seen_c: cover property (blank_now ##1 !blank_now);
   write_done_c: cover property (s_axi_bvalid && s_axi_bready);
   filter_on_c: cover property (filter_reg[cbf_pkg::BIT_FILT_EN]
      && cmp_raw ##[1:20] cmp_conditioned);
   read_done_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

/* tb/cbf_sources.sv */
/*
 comparator and mask source model for the blanking filter bench.
 assumes the bench sets levels by non-blocking assignment on aclk.
*/
`default_nettype none
module cbf_sources (
   input  wire logic             aclk,
   input  wire logic             cmp_level,
   input  wire logic             mask_level,
   output logic                  cmp_raw,
   output logic [15:0]           mask_sources,
   output cbf_pkg::cbf_clk_type  filter_clocks
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt = 8'h00;
   // free running tick sources, slowest rises every 256 cycles
   assign filter_clocks = cbf_pkg::cbf_clk_type'(cnt);
   always @(posedge aclk) begin
      cnt <= cnt + 8'h01;
      cmp_raw <= cmp_level;
      mask_sources <= {16{mask_level}};
   end
endmodule
`default_nettype wire

/* tb/tb_cbf_top.sv */
/*
 bench for the blanking filter: registers, gating, filter, references.
 assumes cbf_sources stands in for the comparator and mask sources.
*/
`default_nettype none
module tb_cbf_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic awr, wrd, bv, arr, rv, cc, blk, cr, cl = 0, ml = 0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd, got;
   logic [1:0] bre, rre, resp;
   logic [15:0] ms;
   cbf_pkg::cbf_clk_type fc;
   cbf_pkg::cbf_ref_type r1, r2;
   int failures = 0, n_checks = 0;
   always #50 aclk = ~aclk;
   cbf_sources cbf_sources_inst (.aclk(aclk), .cmp_level(cl),
      .mask_level(ml), .cmp_raw(cr), .mask_sources(ms), .filter_clocks(fc));
   cbf_top cbf_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .cmp_raw(cr), .mask_sources(ms),
      .filter_clocks(fc), .cmp_conditioned(cc), .blank_active(blk),
      .ref_one(r1), .ref_two(r2));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // requests held until ready seen settled at the falling edge
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ga, gw, da, dw;
      da = 0; dw = 0;
      @(posedge aclk); awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
      while (!(da && dw)) begin
         @(negedge aclk); ga = awr; gw = wrd;
         @(posedge aclk);
         if (ga) begin awv <= 0; da = 1; end
         if (gw) begin wv <= 0; dw = 1; end
      end
      da = 0;
      while (!da) begin
         @(negedge aclk);
         if (bv) begin @(posedge aclk); resp = bre; br <= 0; da = 1; end
      end
   endtask
   task rdt(input logic [7:0] a);
      logic da, ga;
      da = 0;
      @(posedge aclk); ara <= a; arv <= 1; rr <= 1;
      while (!da) begin
         @(negedge aclk); ga = arr;
         @(posedge aclk); if (ga) begin arv <= 0; da = 1; end
      end
      da = 0;
      while (!da) begin
         @(negedge aclk);
         if (rv) begin
            @(posedge aclk); got = rd; resp = rre; rr <= 0; da = 1;
         end
      end
   endtask
   task t_regs;
      logic [7:0] ad [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
      logic [15:0] mk [5] = '{16'hBFFF, 16'h007F, 16'h0CFF, 16'h0CFF, 16'h0FFF};
      for (int i = 0; i < 5; i++) begin
         rdt(ad[i]); chk("reset", 32'h0, got);
         wr(ad[i], 32'hFFFF_FFFF); rdt(ad[i]); chk("rw", {16'h0, mk[i]}, got);
      end
      chk("ref1", 32'h3FF, 32'(r1));
      wr(8'h14, 32'h7); chk("ro", 32'h2, 32'(resp));
      rdt(8'h18); chk("unmap", 32'h2, 32'(resp));
      wr(8'h08, 32'h0880); wr(8'h0C, 32'h0020); @(posedge aclk);
      chk("ref1", 32'h280, 32'(r1));
      chk("ref2", 32'h040, 32'(r2));
      wr(8'h10, 32'h0); wr(8'h04, 32'h0); $display("test regs done");
   endtask
   task t_gate;
      logic [15:0] cf [11] = '{16'h0200, 16'h0200, 16'h0100, 16'h0100,
         16'h2000, 16'h0800, 16'h0042, 16'h0042, 16'h0082, 16'h0082, 16'h0040};
      logic ml_t [11] = '{1, 0, 0, 1, 1, 1, 1, 0, 0, 1, 1};
      logic ex [11] = '{1, 0, 1, 0, 1, 1, 1, 0, 1, 0, 0};
      for (int p = 0; p < 2; p++) for (int i = 0; i < 11; i++) begin
         wr(8'h00, {16'h0, p[0], cf[i][14:0]});
         ml <= ml_t[i]; cl <= !p[0];
         repeat (4) @(posedge aclk);
         chk("blank", 32'(ex[i]), 32'(blk));
         chk("cmp", 32'(ex[i] ? p[0] : !p[0]), 32'(cc));
      end
      wr(8'h00, 32'h0); $display("test gate done");
   endtask
   task t_filt(input logic [7:0] cfg, input int hold);
      wr(8'h04, 32'(cfg)); cl <= 0;
      repeat (hold) @(posedge aclk);
      cl <= 1; repeat (2) @(posedge aclk); cl <= 0;
      repeat (hold) @(posedge aclk);
      chk("glitch", 32'h0, 32'(cc));
      cl <= 1; repeat (hold) @(posedge aclk);
      chk("level", 32'h1, 32'(cc));
   endtask
   initial begin
      repeat (50000) @(posedge aclk);
      failures++;
      tally_and_finish;
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_gate;
      for (int s = 0; s < 8; s++) t_filt({1'b0, s[2:0], 4'h8}, 1100);
      t_filt(8'h1F, 700);
      $display("test filter done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
